// file: rtl/ahp_pkg.sv
package ahp_pkg;
  // bus geometry
  localparam int DATA_W = 13;
  localparam int NARROW_W = 8;
  localparam int CFG_W = 13;
  // configuration field positions
  localparam int CFG_SYNC_IN_BIT = 8;
  localparam int CFG_BW_BIT = 12;
  localparam int CFG_CH_LSB = 0;
  localparam int CFG_CH_W = 4;
  localparam int CH_HALF_W = 2;
  // reset values
  localparam logic [12:0] CFG_RESET = 13'h0000;
  localparam logic [12:0] DATA_ZERO = 13'h0000;
  localparam logic [12:0] NARROW_MASK = 13'h00ff;
  localparam logic [3:0] CH_RESET = 4'h0;
  // conversion timing, in clock cycles
  localparam int CONV_CYCLES = 16;
  localparam logic [4:0] CONV_LAST = 5'h0f;
  localparam logic [4:0] CONV_ZERO = 5'h00;

  // bus strobes as seen by the port after synchronising
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } ahp_strobe_t;

  // converter core states
  typedef enum logic [1:0] {
    AHP_IDLE = 2'b00,
    AHP_CONV = 2'b01,
    AHP_DONE = 2'b10
  } ahp_state_t;
endpackage : ahp_pkg

// file: rtl/ahp_port.sv
`timescale 1ns/1ns
// Functional notes
// RL1: strap at power-up picks write latch edge
// RL2: host keeps strap constant after power-up
// RL3: b8 set: sync rising edge starts conversion
// RL4: b8 clear: sync driven high during conversion
// RL5: b12 clear: upper five data lines float
// RL6: data line 12 is msb, 0 lsb
// RL7: conversion clock between 0.05 and 12 MHz; conversions here count cycles of the 100 MHz system clock
// RL8: input buffers on only with cs and wr low
// RL9: drive data only with cs and rd low
// RL10: ready low flags function start or end
// RL11: standby pin low only while in standby
// RL12: channel field b3..b0 drives selector outputs
// RL13: config written by bus, applied after latch
module ahp_port (
  input wire logic clk, // 100 MHz system clock
  input wire logic rst_b, // sync reset, active low
  input wire logic write_edge_select_strap, // latch edge strap pin
  input wire logic cs_n, // chip select pin
  input wire logic rd_n, // read strobe pin
  input wire logic wr_n, // write strobe pin
  input wire logic [12:0] data_lines_in, // data pins as seen
  output logic [12:0] data_lines_out, // data pin drive values
  output logic [12:0] data_lines_oe, // data pin enables, high drives
  output logic data_in_buf_en, // data input buffers enabled
  input wire logic sync_in, // sync pin level
  output logic sync_out, // sync pin drive value
  output logic sync_oe, // sync pin enable
  input wire logic [12:0] conv_result, // result from converter core
  input wire logic standby_req, // core asks to enter standby
  input wire logic wake_req, // host asks to leave standby
  output logic ready_n, // ready flag, active low
  output logic low_power_indicator_n, // standby flag, active low
  output logic [1:0] selector_output_pos, // positive selector code
  output logic [1:0] selector_output_neg // negative selector code
);
  ahp_pkg::ahp_strobe_t strobe; // synchronised strobes
  ahp_pkg::ahp_strobe_t strobe_d; // previous strobes for edges
  logic [12:0] data_s; // synchronised data pins
  logic strap_s; // synchronised strap
  logic sync_s; // synchronised sync pin
  logic sync_d; // previous sync level
  logic strap; // strap caught after reset
  logic strap_taken; // strap capture done
  logic strap_wait; // first edge after release has passed
  logic strap_settled; // synchroniser no longer shows its reset park
  logic [12:0] cfg; // configuration register
  ahp_pkg::ahp_state_t state; // conversion state
  logic [4:0] conv_cnt; // conversion cycle counter
  logic [12:0] result; // last finished result
  logic in_standby; // standby state
  logic next_strap;
  logic next_strap_taken;
  logic next_strap_wait;
  logic next_strap_settled;
  logic [12:0] next_cfg;
  logic [12:0] next_result;
  ahp_pkg::ahp_state_t next_state;
  logic [4:0] next_conv_cnt;
  logic next_in_standby;
  logic [12:0] next_data_out;
  logic [12:0] next_data_oe;
  logic next_in_buf_en;
  logic next_sync_out;
  logic next_sync_oe;
  logic next_ready_n;
  logic next_lp_n;
  logic [1:0] next_pos;
  logic [1:0] next_neg;
  logic wr_rise; // write strobe went high while selected
  logic wr_fall; // write strobe went low while selected
  logic latch; // configured latching edge seen
  logic start; // conversion start request
  logic wide; // 13-line bus mode

  // lane mask for the active width
  function automatic logic [12:0] lane_mask(input logic wide_mode);
    lane_mask = wide_mode ? '1 : ahp_pkg::NARROW_MASK;
  endfunction : lane_mask

  // all pin inputs pass two flops first: 3 strobes, strap, sync, 13 data lines
  ahp_sync2 #(.W(18)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({cs_n, rd_n, wr_n, write_edge_select_strap, sync_in, data_lines_in}),
    .q({strobe, strap_s, sync_s, data_s})
  );

  // edge detection works from synchronised copies only
  always_comb begin
    wr_rise = !strobe_d.cs_n && !strobe_d.wr_n && strobe.wr_n;
    wr_fall = !strobe.cs_n && strobe_d.wr_n && !strobe.wr_n;
    latch = strap ? wr_fall : wr_rise; // RL1
    wide = cfg[ahp_pkg::CFG_BW_BIT];
    // sync edge only counts when the pin is an input
    start = cfg[ahp_pkg::CFG_SYNC_IN_BIT] && sync_s && !sync_d; // RL3
  end

  // strap capture and configuration write
  always_comb begin
    next_strap = strap;
    next_strap_taken = strap_taken;
    next_strap_wait = strap_wait;
    next_strap_settled = strap_settled;
    next_cfg = cfg;
    if (!rst_b) begin
      next_strap = 1'b0;
      next_strap_taken = 1'b0;
      next_strap_wait = 1'b0;
      next_strap_settled = 1'b0;
      next_cfg = ahp_pkg::CFG_RESET;
    end else begin
      // the synchroniser shows its parked high for two edges after release,
      // so the strap copy is only trusted once both stages hold the pin
      next_strap_wait = 1'b1;
      next_strap_settled = strap_wait;
      // catch once after release; later changes ignored since the board holds it
      if (strap_settled && !strap_taken) begin
        next_strap = strap_s; // RL1 RL2
        next_strap_taken = 1'b1;
      end
      // rising-edge mode samples the data seen in the same cycle as the risen strobe;
      // all thirteen lines are taken, else the width bit could never be set
      if (strap_taken && latch) begin
        next_cfg = data_s; // RL13 RL6
      end
    end
  end

  always_ff @(posedge clk) begin
    strap <= next_strap;
    strap_taken <= next_strap_taken;
    strap_wait <= next_strap_wait;
    strap_settled <= next_strap_settled;
    cfg <= next_cfg;
    strobe_d <= rst_b ? strobe : '1;
    sync_d <= rst_b ? sync_s : 1'b0;
  end

  // conversion sequencer and standby tracking
  always_comb begin
    next_state = state;
    next_conv_cnt = conv_cnt;
    next_result = result;
    next_in_standby = in_standby;
    if (!rst_b) begin
      next_state = ahp_pkg::AHP_IDLE;
      next_conv_cnt = ahp_pkg::CONV_ZERO;
      next_result = ahp_pkg::DATA_ZERO;
      next_in_standby = 1'b0;
    end else begin
      // wake wins over a standby request in the same cycle
      if (wake_req) begin
        next_in_standby = 1'b0;
      end else if (standby_req && state == ahp_pkg::AHP_IDLE) begin
        next_in_standby = 1'b1;
      end
      unique case (state)
        ahp_pkg::AHP_IDLE: begin
          if (start && !in_standby) begin
            next_state = ahp_pkg::AHP_CONV;
            next_conv_cnt = ahp_pkg::CONV_ZERO;
          end
        end
        ahp_pkg::AHP_CONV: begin
          next_conv_cnt = conv_cnt + 5'h01;
          if (conv_cnt == ahp_pkg::CONV_LAST) begin
            next_state = ahp_pkg::AHP_DONE;
            next_result = conv_result;
          end
        end
        ahp_pkg::AHP_DONE: begin
          next_state = ahp_pkg::AHP_IDLE;
        end
        default: begin
          next_state = ahp_pkg::AHP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
    conv_cnt <= next_conv_cnt;
    result <= next_result;
    in_standby <= next_in_standby;
  end

  // pin drive: every output straight from a flop
  always_comb begin
    next_data_out = ahp_pkg::DATA_ZERO;
    next_data_oe = ahp_pkg::DATA_ZERO;
    next_in_buf_en = 1'b0;
    next_sync_out = 1'b0;
    next_sync_oe = 1'b0;
    next_ready_n = 1'b1;
    next_lp_n = 1'b1;
    next_pos = 2'h0;
    next_neg = 2'h0;
    if (rst_b) begin
      // read drive only while selected and read low; upper lanes float when narrow
      if (!strobe.cs_n && !strobe.rd_n) begin
        next_data_out = result & lane_mask(wide); // RL9 RL6
        next_data_oe = lane_mask(wide); // RL5 RL9
      end
      next_in_buf_en = !strobe.cs_n && !strobe.wr_n; // RL8
      // output mode: high for the whole conversion
      next_sync_oe = !cfg[ahp_pkg::CFG_SYNC_IN_BIT]; // RL4
      next_sync_out = next_sync_oe && next_state == ahp_pkg::AHP_CONV; // RL4
      // ready pulses low at start and at end of conversion
      next_ready_n = !(next_state == ahp_pkg::AHP_DONE ||
                       (state == ahp_pkg::AHP_IDLE && next_state == ahp_pkg::AHP_CONV)); // RL10
      // leaving standby releases the pin at once
      next_lp_n = !(next_in_standby && !wake_req); // RL11
      next_pos = cfg[ahp_pkg::CFG_CH_LSB +: ahp_pkg::CH_HALF_W]; // RL12
      next_neg = cfg[ahp_pkg::CFG_CH_LSB + ahp_pkg::CH_HALF_W +: ahp_pkg::CH_HALF_W]; // RL12
    end
  end

  always_ff @(posedge clk) begin
    data_lines_out <= next_data_out;
    data_lines_oe <= next_data_oe;
    data_in_buf_en <= next_in_buf_en;
    sync_out <= next_sync_out;
    sync_oe <= next_sync_oe;
    ready_n <= next_ready_n;
    low_power_indicator_n <= next_lp_n;
    selector_output_pos <= next_pos;
    selector_output_neg <= next_neg;
  end

  // checks
  a_narrow_float: assert property (@(posedge clk) disable iff (!rst_b) // RL5
    !cfg[ahp_pkg::CFG_BW_BIT] && $stable(cfg) |=> data_lines_oe[12:8] == 5'h00)
    else $error("upper data lines driven in narrow mode");
  a_read_gate: assert property (@(posedge clk) disable iff (!rst_b) // RL9
    (strobe.cs_n || strobe.rd_n) |=> data_lines_oe == ahp_pkg::DATA_ZERO)
    else $error("data driven without read select");
  a_write_gate: assert property (@(posedge clk) disable iff (!rst_b) // RL8
    data_in_buf_en |-> !$past(strobe.cs_n) && !$past(strobe.wr_n))
    else $error("input buffers on without write select");
  a_sync_start: assert property (@(posedge clk) disable iff (!rst_b) // RL3
    start && state == ahp_pkg::AHP_IDLE && !in_standby |=> state == ahp_pkg::AHP_CONV)
    else $error("sync edge did not start conversion");
  a_sync_high: assert property (@(posedge clk) disable iff (!rst_b) // RL4
    sync_oe && $rose(sync_out) |-> sync_out [*8])
    else $error("sync output dropped early");
  a_sync_end: assert property (@(posedge clk) disable iff (!rst_b) // RL4
    sync_oe && $rose(sync_out) |-> ##[1:20] !sync_out)
    else $error("sync output never fell");
  a_ready_end: assert property (@(posedge clk) disable iff (!rst_b) // RL10
    state == ahp_pkg::AHP_DONE |-> !ready_n)
    else $error("ready missing at conversion end");
  a_cfg_latch: assert property (@(posedge clk) disable iff (!rst_b) // RL13
    strap_taken && latch |=> cfg == $past(data_s))
    else $error("configuration not applied");
  a_standby_pin: assert property (@(posedge clk) disable iff (!rst_b) // RL11
    wake_req |=> low_power_indicator_n)
    else $error("standby pin low after wake request");
  a_mux_route: assert property (@(posedge clk) disable iff (!rst_b) // RL12
    $stable(cfg) |=> selector_output_pos == $past(cfg[1:0]))
    else $error("selector output does not follow channel field");
  // the strap is read once; a later pin change must not move the latch edge
  a_strap_hold: assert property (@(posedge clk) disable iff (!rst_b) // RL1
    strap_taken && $past(strap_taken) |-> $stable(strap))
    else $error("latch edge choice moved after capture");
  a_sync_in_quiet: assert property (@(posedge clk) disable iff (!rst_b) // RL3
    cfg[ahp_pkg::CFG_SYNC_IN_BIT] |=> !sync_oe)
    else $error("sync pin driven while it is an input");
  a_ready_start: assert property (@(posedge clk) disable iff (!rst_b) // RL10
    $rose(state == ahp_pkg::AHP_CONV) |-> !ready_n)
    else $error("ready missing at conversion start");
  a_result_latch: assert property (@(posedge clk) disable iff (!rst_b) // RL3
    state == ahp_pkg::AHP_CONV && conv_cnt == ahp_pkg::CONV_LAST |=>
      result == $past(conv_result))
    else $error("result not taken at conversion end");
  // wide reads must drive every line, not only the low byte
  a_wide_drive: assert property (@(posedge clk) disable iff (!rst_b) // RL5
    !strobe.cs_n && !strobe.rd_n && wide |=> &data_lines_oe)
    else $error("wide read left lines floating");
  a_read_data: assert property (@(posedge clk) disable iff (!rst_b) // RL6
    !strobe.cs_n && !strobe.rd_n |=> data_lines_out == ($past(result) & data_lines_oe))
    else $error("read data not on matching lines");
  a_buf_follow: assert property (@(posedge clk) disable iff (!rst_b) // RL8
    !strobe.cs_n && !strobe.wr_n |=> data_in_buf_en)
    else $error("input buffers off during write select");
  a_neg_route: assert property (@(posedge clk) disable iff (!rst_b) // RL12
    $stable(cfg) |=> selector_output_neg == $past(cfg[3:2]))
    else $error("negative selector does not follow channel field");
  c_conv_done: cover property (@(posedge clk) disable iff (!rst_b)
    state == ahp_pkg::AHP_DONE);
  c_read_wide: cover property (@(posedge clk) disable iff (!rst_b)
    data_lines_oe[12]);
  c_cfg_write: cover property (@(posedge clk) disable iff (!rst_b)
    strap_taken && latch);
  c_standby: cover property (@(posedge clk) disable iff (!rst_b)
    !low_power_indicator_n);
  // a conversion launched from the sync input
  c_sync_start: cover property (@(posedge clk) disable iff (!rst_b)
    start && state == ahp_pkg::AHP_IDLE && !in_standby);
endmodule : ahp_port

// file: rtl/ahp_sync2.sv
`timescale 1ns/1ns
// two-flop synchroniser for a small group of pin levels
module ahp_sync2 #(
  parameter int W = 1
) (
  input wire logic clk, // system clock
  input wire logic rst_b, // sync reset, active low
  input wire logic [W-1:0] d, // asynchronous pins
  output logic [W-1:0] q // synchronised levels
);
  logic [W-1:0] meta; // first stage, read only by q
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // reset parks both stages high, matching idle strobes
  always_comb begin
    next_meta = rst_b ? d : '1;
    next_q = rst_b ? meta : '1;
  end

  always_ff @(posedge clk) begin
    meta <= next_meta;
    q <= next_q;
  end
endmodule : ahp_sync2

// file: tb/ahp_host_model.sv
`timescale 1ns/1ns
// host bus master; a released bus toggles so a stale value never matches
module ahp_host_model (
  input wire logic clk, // system clock
  input wire logic [12:0] dut_out, // device drive values
  input wire logic [12:0] dut_oe, // device drive enables
  input wire logic buf_en, // device input buffer flag
  output logic cs_n, // chip select
  output logic rd_n, // read strobe
  output logic wr_n, // write strobe
  output logic [12:0] data_lines_in // resolved bus level
);
  logic drv = 1'b0; // host drives the bus
  logic [12:0] val = 13'h0000; // host data
  logic idle = 1'b0; // floating pattern
  logic buf_mid = 1'b0; // buffer flag seen mid write
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
  end
  // pattern flips every cycle for undriven lines
  always @(posedge clk) begin
    idle <= ~idle;
  end
  // device enables win, then host, then the pattern
  assign data_lines_in = (dut_oe & dut_out) | (~dut_oe & (drv ? val : {13{idle}}));
  // data changes mid strobe, so each latch edge sees its own word
  task automatic write_word(input logic [12:0] d_fall, input logic [12:0] d_rise);
    @(posedge clk);
    #1 cs_n = 1'b0;
    wr_n = 1'b0;
    drv = 1'b1;
    val = d_fall;
    repeat (4) @(posedge clk);
    #1 buf_mid = buf_en;
    repeat (2) @(posedge clk);
    #1 val = d_rise;
    repeat (6) @(posedge clk);
    #1 wr_n = 1'b1;
    repeat (5) @(posedge clk);
    #1 cs_n = 1'b1;
    drv = 1'b0;
    repeat (3) @(posedge clk);
  endtask : write_word
  // read cycle held well past the answer latency
  task automatic read_word(output logic [12:0] v, output logic [12:0] oe);
    @(posedge clk);
    #1 cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (5) @(posedge clk);
    #1 v = dut_out;
    oe = dut_oe;
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (5) @(posedge clk);
  endtask : read_word
endmodule : ahp_host_model

// file: tb/ahp_port_bench.sv
`timescale 1ns/1ns
// bench for the parallel host port
module ahp_port_bench;
  logic clk = 1'b0; // system clock
  logic rst_b = 1'b0; // sync reset
  logic strap = 1'b0; // latch edge strap
  logic sync_in = 1'b0; // sync pin level
  logic standby_req = 1'b0; // enter standby
  logic wake_req = 1'b0; // leave standby
  logic cs_n, rd_n, wr_n, buf_en, sync_out, sync_oe, ready_n, lpi_n;
  logic [12:0] d_in, d_out, d_oe, v, oe;
  logic [1:0] pos, neg;
  int err_total = 0;
  int n_tests = 0;
  int k;
  int n_rdy = 0; // ready pulses seen
  ahp_port dut (.clk(clk), .rst_b(rst_b), .write_edge_select_strap(strap), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .data_lines_in(d_in), .data_lines_out(d_out),
    .data_lines_oe(d_oe), .data_in_buf_en(buf_en), .sync_in(sync_in), .sync_out(sync_out),
    .sync_oe(sync_oe), .conv_result(13'h1abc), .standby_req(standby_req),
    .wake_req(wake_req), .ready_n(ready_n), .low_power_indicator_n(lpi_n),
    .selector_output_pos(pos), .selector_output_neg(neg));
  ahp_host_model host (.clk(clk), .dut_out(d_out), .dut_oe(d_oe), .buf_en(buf_en),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .data_lines_in(d_in));
  // 100 MHz, above the allowed 0.05 to 12 MHz conversion clock range
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic tally_and_finish;
    if (err_total == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // strap only moves while reset holds the port
  task automatic do_reset(input logic s);
    @(posedge clk);
    #1 rst_b = 1'b0;
    strap = s;
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (6) @(posedge clk);
  endtask : do_reset
  // bounded wait for the standby flag
  task automatic wait_lpi(input logic lvl);
    for (k = 0; k < 40 && lpi_n !== lvl; k++) begin
      @(posedge clk);
      #1;
    end
    chk(13'(lpi_n), 13'(lvl), "standby flag");
  endtask : wait_lpi
  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    do_reset(1'b0);
    chk(13'(sync_oe), 13'h0001, "sync not driven");
    chk(13'(ready_n), 13'h0001, "ready after reset");
    // every channel code, latched on the rising strobe
    for (int c = 0; c < 16; c++) begin
      host.write_word(13'h00f0 ^ 13'(c), 13'(c));
      repeat (2) @(posedge clk);
      chk(13'({neg, pos}), 13'(c), "selector code");
      chk(13'(host.buf_mid), 13'h0001, "input buffer in write");
      chk(13'(buf_en), 13'h0000, "input buffer idle");
    end
    // narrow mode drops the upper five lines
    host.write_word(13'h0000, 13'h0006);
    repeat (2) @(posedge clk);
    chk(13'({sync_oe, neg, pos}), 13'h0016, "narrow mask");
    host.read_word(v, oe);
    chk(oe, 13'h00ff, "narrow drive");
    chk(v & 13'h00ff, 13'h0000, "read value");
    chk(d_oe, 13'h0000, "bus released");
    // sync edge ignored while the pin is an output
    #1 sync_in = 1'b1;
    for (k = 0; k < 30; k++) begin
      @(posedge clk);
      #1 chk(13'({ready_n, sync_out}), 13'h0002, "no start");
    end
    sync_in = 1'b0;
    // wide bus, sync as input: one edge gives one conversion
    host.write_word(13'h0000, 13'h1106);
    repeat (2) @(posedge clk);
    chk(13'({sync_oe, neg, pos}), 13'h0006, "sync input config");
    #1 sync_in = 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      #1;
      if (!ready_n) n_rdy++;
    end
    chk(13'(n_rdy), 13'h0002, "ready pulses");
    sync_in = 1'b0;
    host.read_word(v, oe);
    chk(oe, 13'h1fff, "wide drive");
    chk(v, 13'h1abc, "conversion result");
    standby_req = 1'b1;
    wait_lpi(1'b0);
    #1 standby_req = 1'b0;
    wake_req = 1'b1;
    wait_lpi(1'b1);
    #1 wake_req = 1'b0;
    // falling strobe latches the first word
    do_reset(1'b1);
    host.write_word(13'h0009, 13'h0006);
    repeat (2) @(posedge clk);
    chk(13'({neg, pos}), 13'h0009, "falling latch");
    tally_and_finish();
  end
endmodule : ahp_port_bench
